// ### rtl/crsc_params.svh
// Timing and field constants for the reset and sleep controller pair.
// Assumes a 250 MHz core clock; included by the package and both ends.
`ifndef CRSC_PARAMS_SVH
`define CRSC_PARAMS_SVH

// ****************************************************************
// Timing and widths
// ****************************************************************
`define CRSC_CLK_MHZ       250
`define CRSC_RST_MIN_US    1000
`define CRSC_RST_MAX_US    10000
`define CRSC_RST_MIN_CYC   (`CRSC_RST_MIN_US * `CRSC_CLK_MHZ)
`define CRSC_RST_MAX_CYC   (`CRSC_RST_MAX_US * `CRSC_CLK_MHZ)
`define CRSC_DROP_CYC      2
`define CRSC_CFG_W         8
`define CRSC_CNT_W         24

`endif

// ### rtl/crsc_pkg.sv
// Types shared by the device and platform ends.
// Assumes crsc_params.svh is on the include path.
`include "crsc_params.svh"
package crsc_pkg;
    // Device power state
    typedef enum logic [2:0] {
        CRSC_OFF,
        CRSC_RESET,
        CRSC_RUN,
        CRSC_GATED,
        CRSC_SLEEP
    } crsc_state_e;
    typedef logic [`CRSC_CFG_W-1:0] crsc_cfg_t;
endpackage

// ### rtl/crsc_if.sv
// Pin bundle between platform logic and the processor control end.
// Assumes one shared core clock; all pins active as named.
`timescale 1ns/1ps
`include "crsc_params.svh"
interface crsc_if;
    logic                      power_ok_in;
    logic                      reset_n;
    logic                      sleep_request_n;
    logic                      stop_clock_request_n;
    logic                      mgmt_interrupt_n;
    logic [`CRSC_CFG_W-1:0]    cfg_pins;
    logic                      bus_out;
    logic                      bus_oe_n;
    modport device (
        input  power_ok_in, reset_n, sleep_request_n,
        input  stop_clock_request_n, mgmt_interrupt_n, cfg_pins,
        output bus_out, bus_oe_n
    );
    modport platform (
        output power_ok_in, reset_n, sleep_request_n,
        output stop_clock_request_n, mgmt_interrupt_n, cfg_pins,
        input  bus_out, bus_oe_n
    );
endinterface

// ### rtl/crsc_device.sv
// Processor end: power-ok qualification, reset, config capture, sleep.
// Assumes platform pins arrive on crsc_if; power-ok and sleep async.
`timescale 1ns/1ps
`include "crsc_params.svh"
module crsc_device
    import crsc_pkg::*;
(
    input  wire logic          core_clk_i,
    input  wire logic          rst_i,
    crsc_if.device             pins,
    input  wire logic          bus_data_i,
    output logic               cache_inval_o,
    output logic               core_clk_en_o,
    output logic               bus_clk_en_o,
    output logic               pll_on_o,
    output logic               snoop_en_o,
    output logic               outputs_tristate_o,
    output crsc_pkg::crsc_cfg_t cfg_o,
    output crsc_pkg::crsc_state_e state_o
);
    import crsc_pkg::*;

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // Strap type and state encoding must match the shared constants
    if ($bits(crsc_cfg_t) != `CRSC_CFG_W) begin : g_bad_cfg_w
        $error("configuration width differs from CRSC_CFG_W");
    end
    if ($bits(crsc_state_e) < 3) begin : g_bad_state_w
        $error("state encoding too narrow");
    end

    // ************************************************************
    // State
    // ************************************************************
    // Everything this end remembers, except the clock and snoop enables, lives in one registered record
    typedef struct packed {
        logic [1:0]  pok_sync;
        logic [1:0]  slp_sync;
        logic        rst_q;
        crsc_state_e st;
        crsc_cfg_t   cfg;
        logic        trist;
        logic        inval;
        logic        bus_out;
        logic        oe_n;
    } crsc_dev_s;

    crsc_dev_s r;
    crsc_dev_s next_r;
    logic      pok;
    logic      slp_n;
    logic      rst_act;
    logic      next_core_en;
    logic      next_bus_en;
    logic      next_pll_on;
    logic      next_snoop_en;

    // ************************************************************
    // Qualified inputs
    // ************************************************************
    // Only the second stage is read; the first may still be
    // settling from an asynchronous edge
    assign pok     = r.pok_sync[1];
    assign slp_n   = r.slp_sync[1];
    // A low reset pin or a lost power-ok both count as reset,
    // so a supply drop cannot leave the core running alone
    assign rst_act = ~pins.reset_n | ~pok;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_r          = r;
        next_r.pok_sync = {r.pok_sync[0], pins.power_ok_in};
        next_r.slp_sync = {r.slp_sync[0], pins.sleep_request_n};
        next_r.rst_q    = rst_act;
        next_r.inval    = 1'b0;
        next_r.bus_out  = bus_data_i;
        // Reset dominates any power state
        if (rst_act) begin
            next_r.st      = pok ? CRSC_RESET : CRSC_OFF;
            next_r.inval   = 1'b1;
            next_r.oe_n    = 1'b1;
            next_r.bus_out = 1'b0;
        end else if (r.rst_q) begin
            // Release edge: sample straps and management pin
            next_r.cfg   = pins.cfg_pins;
            next_r.trist = ~pins.mgmt_interrupt_n;
            next_r.st    = CRSC_RUN;
            next_r.oe_n  = ~pins.mgmt_interrupt_n;
        end else begin
            next_r.oe_n = r.trist;
            case (r.st)
                CRSC_RUN: begin
                    if (!pins.stop_clock_request_n) begin
                        next_r.st = CRSC_GATED;
                    end
                end
                CRSC_GATED: begin
                    if (!slp_n) begin
                        next_r.st = CRSC_SLEEP;
                    end else if (pins.stop_clock_request_n) begin
                        next_r.st = CRSC_RUN;
                    end
                end
                CRSC_SLEEP: begin
                    // Only sleep release wakes; stop-clock ignored
                    if (slp_n) begin
                        next_r.st = CRSC_GATED;
                    end
                end
                default: begin
                    next_r.st = CRSC_RESET;
                end
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r          <= '0;
            r.st       <= CRSC_OFF;
            r.rst_q    <= 1'b1;
            r.inval    <= 1'b1;
            r.oe_n     <= 1'b1;
            r.slp_sync <= 2'h3;
        end else begin
            r <= next_r;
        end
    end

    // ************************************************************
    // Clock and snoop enables
    // ************************************************************
    // Decoded from the next state so the enables change on the
    // same edge as state_o, with no extra cycle of skew
    always_comb begin
        next_core_en  = 1'b0;
        next_bus_en   = 1'b0;
        next_pll_on   = 1'b1;
        next_snoop_en = 1'b0;
        case (next_r.st)
            CRSC_OFF: begin
                next_pll_on = 1'b0;
            end
            CRSC_RESET: begin
                // Held quiet until the release edge
                next_core_en = 1'b0;
            end
            CRSC_RUN: begin
                next_core_en  = 1'b1;
                next_bus_en   = 1'b1;
                next_snoop_en = 1'b1;
            end
            CRSC_GATED: begin
                // Core stopped; bus unit and snooping stay alive
                next_bus_en   = 1'b1;
                next_snoop_en = 1'b1;
            end
            CRSC_SLEEP: begin
                // Only the PLL keeps running; snoops go unseen
                next_snoop_en = 1'b0;
            end
            default: begin
                next_pll_on = 1'b0;
            end
        endcase
    end

    // Output clock enables are registered
    logic core_en_q;
    logic bus_en_q;
    logic pll_q;
    logic snoop_q;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            core_en_q <= 1'b0;
            bus_en_q  <= 1'b0;
            pll_q     <= 1'b0;
            snoop_q   <= 1'b0;
        end else begin
            core_en_q <= next_core_en;
            bus_en_q  <= next_bus_en;
            pll_q     <= next_pll_on;
            snoop_q   <= next_snoop_en;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Every output is a register read straight out
    assign core_clk_en_o      = core_en_q;
    assign bus_clk_en_o       = bus_en_q;
    assign pll_on_o           = pll_q;
    assign snoop_en_o         = snoop_q;
    assign cache_inval_o      = r.inval;
    assign outputs_tristate_o = r.trist;
    assign cfg_o              = r.cfg;
    assign state_o            = r.st;
    assign pins.bus_out       = r.bus_out;
    assign pins.bus_oe_n      = r.oe_n;
endmodule

// ### rtl/crsc_platform.sv
// Platform end: sequences power-ok, reset pulse, stop-clock and sleep.
// Assumes user requests are synchronous, one clock domain.
`timescale 1ns/1ps
`include "crsc_params.svh"
module crsc_platform
    import crsc_pkg::*;
#(
    parameter int RST_CYC = `CRSC_RST_MIN_CYC
)
(
    input  wire logic          core_clk_i,
    input  wire logic          rst_i,
    crsc_if.platform           pins,
    input  wire logic          supplies_ok_i,
    input  wire logic          sleep_req_i,
    input  wire logic          mgmt_req_i,
    input  wire logic [`CRSC_CFG_W-1:0] straps_i,
    output logic               in_reset_o,
    output logic               asleep_o
);
    import crsc_pkg::*;

    // Pulse must fit the counter and stay under the hold limit
    if (RST_CYC < 1 || RST_CYC >= `CRSC_RST_MAX_CYC ||
        RST_CYC >= (1 << `CRSC_CNT_W)) begin : g_bad_rst_cyc
        $error("RST_CYC out of range");
    end

    typedef enum logic [2:0] {
        CRSC_P_OFF, CRSC_P_RST, CRSC_P_RUN, CRSC_P_STOP, CRSC_P_SLP
    } crsc_pstate_e;

    typedef struct packed {
        crsc_pstate_e           st;
        logic [`CRSC_CNT_W-1:0] cnt;
        logic                   pok;
        logic                   rst_n;
        logic                   stp_n;
        logic                   slp_n;
        logic                   smi_n;
    } crsc_plat_s;

    crsc_plat_s r;
    crsc_plat_s next_r;

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        next_r       = r;
        next_r.smi_n = ~mgmt_req_i;
        if (!supplies_ok_i) begin
            // Drop power-ok and reset together, cleanly
            next_r.st    = CRSC_P_OFF;
            next_r.pok   = 1'b0;
            next_r.rst_n = 1'b0;
            // Sleep is released first; stop-clock a cycle later
            next_r.stp_n = r.slp_n;
            next_r.slp_n = 1'b1;
        end else begin
            case (r.st)
                CRSC_P_OFF: begin
                    next_r.pok = 1'b1;
                    next_r.cnt = '0;
                    next_r.st  = CRSC_P_RST;
                end
                CRSC_P_RST: begin
                    // Fixed length keeps well under the max hold
                    next_r.cnt = r.cnt + 1'b1;
                    if (r.cnt == RST_CYC[`CRSC_CNT_W-1:0] - 1'b1) begin
                        next_r.rst_n = 1'b1;
                        next_r.st    = CRSC_P_RUN;
                    end
                end
                CRSC_P_RUN: begin
                    if (sleep_req_i) begin
                        next_r.stp_n = 1'b0;
                        next_r.st    = CRSC_P_STOP;
                    end
                end
                CRSC_P_STOP: begin
                    // Sleep only inside the stop-clock window
                    if (sleep_req_i && r.slp_n) begin
                        next_r.slp_n = 1'b0;
                        next_r.st    = CRSC_P_SLP;
                    end else if (!sleep_req_i) begin
                        next_r.stp_n = 1'b1;
                        next_r.st    = CRSC_P_RUN;
                    end
                end
                CRSC_P_SLP: begin
                    if (!sleep_req_i) begin
                        next_r.slp_n = 1'b1;
                        next_r.st    = CRSC_P_STOP;
                    end
                end
                default: begin
                    next_r.st = CRSC_P_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r       <= '0;
            r.st    <= CRSC_P_OFF;
            r.stp_n <= 1'b1;
            r.slp_n <= 1'b1;
            r.smi_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign pins.power_ok_in          = r.pok;
    assign pins.reset_n              = r.rst_n;
    assign pins.stop_clock_request_n = r.stp_n;
    assign pins.sleep_request_n      = r.slp_n;
    assign pins.mgmt_interrupt_n     = r.smi_n;
    assign pins.cfg_pins             = straps_i;
    assign in_reset_o                = ~r.rst_n;
    assign asleep_o                  = ~r.slp_n;
endmodule

// ### verification/crsc_props.sv
// Pin assertions between the platform end and the processor end.
// Assumes instantiation beside crsc_if in the bench top; one clock.
`timescale 1ns/1ps
`include "crsc_params.svh"
module crsc_props #(
    parameter int RST_CYC = `CRSC_RST_MIN_CYC
)
(
    input wire logic       core_clk_i,
    input wire logic       rst_i,
    input wire logic       power_ok_in,
    input wire logic       reset_n,
    input wire logic       sleep_request_n,
    input wire logic       stop_clock_request_n,
    input wire logic       mgmt_interrupt_n,
    input wire logic [`CRSC_CFG_W-1:0] cfg_pins,
    input wire logic       bus_out,
    input wire logic       bus_oe_n
);
    // ****************************************************************
    // Helpers
    // ****************************************************************
    int low_cnt;

    // Reset length after power-ok; a drop of power-ok restarts it
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            low_cnt <= 0;
        end else if (!reset_n && power_ok_in) begin
            low_cnt <= low_cnt + 1;
        end else begin
            low_cnt <= 0;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // ****************************************************************
    // Properties
    // ****************************************************************
    reset_release_a: assert property ($fell(reset_n) |-> ##[0:2] bus_oe_n)
        else $error("bus not released after reset");
    reset_held_a: assert property (!reset_n [*3] |-> bus_oe_n)
        else $error("bus driven during reset");
    mgmt_tristate_a: assert property (
        ($rose(reset_n) && !mgmt_interrupt_n) |-> bus_oe_n [*4])
        else $error("bus driven after release with mgmt low");
    pok_reset_a: assert property ($rose(power_ok_in) |-> !reset_n)
        else $error("power-ok rose without reset");
    reset_min_a: assert property ($rose(reset_n) |-> low_cnt >= RST_CYC)
        else $error("reset pulse too short");
    reset_max_a: assert property (low_cnt < `CRSC_RST_MAX_CYC)
        else $error("reset held too long");
    sleep_window_a: assert property (
        !sleep_request_n |-> !stop_clock_request_n)
        else $error("sleep request outside stop-clock");
    sleep_order_a: assert property (
        $rose(stop_clock_request_n) |-> $past(sleep_request_n))
        else $error("stop-clock released before sleep");

    sleep_entry_c: cover property ($fell(sleep_request_n));
    drive_c: cover property ($rose(reset_n) ##[1:4] !bus_oe_n);
    mgmt_c: cover property ($rose(reset_n) && !mgmt_interrupt_n);
endmodule

// ### verification/test_crsc.sv
// Bench joining both ends of the reset and sleep controller pair.
// Assumes the package and interface are compiled first.
`timescale 1ns/1ps
module test_crsc;
    import crsc_pkg::*;
    localparam int RST_CYC = 16;
    logic        core_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        supplies_ok = 1'b0;
    logic        sleep_req = 1'b0;
    logic        mgmt_req = 1'b0;
    logic        bus_data = 1'b0;
    logic [7:0]  straps = 8'h00;
    logic        inval, core_en, bus_en, pll_on, snoop_en, tristate;
    logic        in_reset, asleep;
    crsc_cfg_t   cfg;
    crsc_state_e state;
    int          num_errors = 0;
    int          n_checks = 0;
    int          cycles = 0;

    crsc_if crsc_if_inst ();
    crsc_device crsc_device_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .pins(crsc_if_inst.device), .bus_data_i(bus_data),
        .cache_inval_o(inval), .core_clk_en_o(core_en),
        .bus_clk_en_o(bus_en), .pll_on_o(pll_on), .snoop_en_o(snoop_en),
        .outputs_tristate_o(tristate), .cfg_o(cfg), .state_o(state));
    crsc_platform #(.RST_CYC(RST_CYC)) crsc_platform_inst (
        .core_clk_i(core_clk_i), .rst_i(rst_i),
        .pins(crsc_if_inst.platform), .supplies_ok_i(supplies_ok),
        .sleep_req_i(sleep_req), .mgmt_req_i(mgmt_req), .straps_i(straps),
        .in_reset_o(in_reset), .asleep_o(asleep));
    crsc_props #(.RST_CYC(RST_CYC)) crsc_props_inst (
        .core_clk_i(core_clk_i), .rst_i(rst_i),
        .power_ok_in(crsc_if_inst.power_ok_in),
        .reset_n(crsc_if_inst.reset_n),
        .sleep_request_n(crsc_if_inst.sleep_request_n),
        .stop_clock_request_n(crsc_if_inst.stop_clock_request_n),
        .mgmt_interrupt_n(crsc_if_inst.mgmt_interrupt_n),
        .cfg_pins(crsc_if_inst.cfg_pins), .bus_out(crsc_if_inst.bus_out),
        .bus_oe_n(crsc_if_inst.bus_oe_n));

    // ****************************************************************
    // Clock, timeout and checking tasks
    // ****************************************************************
    always #2 core_clk_i = ~core_clk_i;

    // Whole run needs under a hundred cycles; a hang ends here
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded wait on the state, then compare it
    task automatic chk_st(input crsc_state_e exp);
        for (int i = 0; i < 100 && state !== exp; i++) begin
            @(negedge core_clk_i);
        end
        n_checks++;
        if (state !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, state, exp);
        end
    endtask

    task automatic power_up(input logic [7:0] s, input logic m);
        straps = s;
        mgmt_req = m;
        supplies_ok = 1'b1;
        chk_st(CRSC_RUN);
    endtask

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        repeat (3) @(posedge core_clk_i);
        @(negedge core_clk_i);
        rst_i = 1'b0;
        chk({inval, crsc_if_inst.bus_oe_n}, 8'h03);
        chk({in_reset, asleep}, 8'h02);
        power_up(8'ha5, 1'b0);
        chk(cfg, 8'ha5);
        chk({in_reset, asleep}, 8'h00);
        chk({inval, crsc_if_inst.bus_oe_n, core_en}, 8'h01);
        bus_data = 1'b1;
        @(negedge core_clk_i);
        chk(crsc_if_inst.bus_out, 8'h01);
        sleep_req = 1'b1;
        chk_st(CRSC_GATED);
        chk({bus_en, snoop_en, core_en}, 8'h06);
        chk_st(CRSC_SLEEP);
        chk({pll_on, bus_en, snoop_en, core_en}, 8'h08);
        chk({in_reset, asleep}, 8'h01);
        sleep_req = 1'b0;
        chk_st(CRSC_GATED);
        chk({bus_en, snoop_en, core_en}, 8'h06);
        chk_st(CRSC_RUN);
        // Power loss while asleep must still reset the core
        sleep_req = 1'b1;
        chk_st(CRSC_SLEEP);
        supplies_ok = 1'b0;
        for (int i = 0; i < 20 && inval !== 1'b1; i++) begin
            @(negedge core_clk_i);
        end
        chk({inval, crsc_if_inst.bus_oe_n, snoop_en}, 8'h06);
        chk({in_reset, asleep, crsc_if_inst.stop_clock_request_n}, 8'h05);
        sleep_req = 1'b0;
        repeat (4) @(negedge core_clk_i);
        power_up(8'h3c, 1'b1);
        chk(cfg, 8'h3c);
        chk({tristate, crsc_if_inst.bus_oe_n}, 8'h03);
        // Let the checker see the tri-state hold run out
        repeat (4) @(negedge core_clk_i);
        chk({tristate, crsc_if_inst.bus_oe_n}, 8'h03);
        final_report();
    end
endmodule
